// ### bench/srbs_checker.sv
// Port-level concurrent checks for the receive buffer block
`timescale 1ns/100ps
module srbs_checker (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Transmit side and interrupt
  input wire logic                        shift_busy,
  input wire logic                        tx_start,
  input wire logic [srbs_pkg::WORD_W-1:0] tx_word,
  input wire logic                        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic                        acc;
  logic                        rd0;
  logic                        ovr_q;
  logic [srbs_pkg::WORD_W-1:0] txw_q;
  assign acc = psel && penable && !pready;
  assign rd0 = pready && !pwrite && paddr == srbs_pkg::OFF_RX_BUF;
  // Only an overrun already seen by a read is tracked
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ovr_q <= 1'b0;
      txw_q <= '0;
    end
    else
    begin
      if (rd0 && prdata[30]) ovr_q <= 1'b1;
      else if (acc && pwrite && paddr == srbs_pkg::OFF_FLAGS && pwdata[1]) ovr_q <= 1'b0;
      if (acc && pwrite && paddr == srbs_pkg::OFF_TX_DATA) txw_q <= pwdata[15:0];
    end
  AST_READY: assert property (acc |=> pready) else $error("no answer after access");
  AST_READY_ONE: assert property (pready |=> !pready) else $error("pready too long");
  AST_ERR_PAIR: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_UNMAPPED: assert property (pready && (paddr > srbs_pkg::OFF_IRQ_ENABLE || paddr[1:0] != 0)
    |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
  AST_MAPPED: assert property (pready && paddr <= srbs_pkg::OFF_IRQ_ENABLE && paddr[1:0] == 0
    |-> !pslverr) else $error("mapped access refused");
  AST_RSVD: assert property (rd0 |-> prdata[23:16] == 8'h00)
    else $error("reserved bits set");
  AST_OVR_KEEP: assert property (rd0 && ovr_q |-> prdata[30])
    else $error("overrun lost on read");
  AST_TX_IDLE: assert property (tx_start |-> !$past(shift_busy))
    else $error("load while shift busy");
  AST_TX_WORD: assert property (tx_start |-> tx_word == txw_q)
    else $error("wrong word loaded");
  AST_IRQ_MASK: assert property (acc && pwrite && paddr == srbs_pkg::OFF_IRQ_ENABLE
    && pwdata[3:0] == 4'h0 |=> !irq) else $error("irq with all masked");
  COV_RD: cover property (rd0 && !prdata[31]);
  COV_TX: cover property (tx_start);
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property (irq);
endmodule : srbs_checker

// ### bench/srbs_shift_model.sv
// Shift engine stand-in: hands over received words, keeps transmit busy
`timescale 1ns/100ps
module srbs_shift_model (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // Bench commands
  input wire logic                        go,
  input wire logic                        err_ev,
  input wire logic [15:0]                 w,
  input wire srbs_pkg::srbs_err_t         e,
  // Block side
  input wire logic                        tx_start,
  output logic                            rx_done,
  output logic [15:0]                     rx_word,
  output srbs_pkg::srbs_err_t             rx_err,
  output logic                            rx_busy,
  output logic                            rx_err_event,
  output logic                            shift_busy
);
  logic [2:0] cnt_q;
  assign shift_busy = cnt_q != 3'h0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= 3'h0;
      rx_done <= 1'b0;
      rx_word <= '0;
      rx_err <= '0;
      rx_busy <= 1'b0;
      rx_err_event <= 1'b0;
    end
    else
    begin
      cnt_q <= tx_start ? 3'h7 : cnt_q - 3'(shift_busy);
      // An error pulse only matters while a receive is under way
      rx_busy <= go | err_ev;
      rx_err_event <= err_ev;
      rx_done <= go;
      // Stale data inverted so no old word looks valid
      rx_word <= go ? w : ~rx_word;
      rx_err <= go ? e : srbs_pkg::srbs_err_t'(~rx_err);
    end
endmodule : srbs_shift_model

// ### bench/test_spi_receive_buffer_status.sv
// Self-checking bench for the receive buffer block
`timescale 1ns/100ps
module test_spi_receive_buffer_status;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, err_ev = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, rx_done, rx_busy, rx_err_event, shift_busy, tx_start, irq, e;
  logic [15:0] rx_word, tx_word, wb = 0;
  srbs_pkg::srbs_err_t rx_err, eb = '0;
  int err_total = 0, checks = 0, nstart = 0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (tx_start === 1'b1) nstart++;
  srbs_receive_buffer srbs_receive_buffer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_done(rx_done), .rx_word(rx_word), .rx_err(rx_err),
    .rx_busy(rx_busy), .rx_err_event(rx_err_event), .shift_busy(shift_busy),
    .tx_start(tx_start), .tx_word(tx_word), .irq(irq));
  srbs_shift_model srbs_shift_model_i (.pclk(pclk), .presetn(presetn), .go(go), .w(wb),
    .e(eb), .err_ev(err_ev), .tx_start(tx_start), .rx_done(rx_done), .rx_word(rx_word),
    .rx_err(rx_err),
    .rx_busy(rx_busy), .rx_err_event(rx_err_event), .shift_busy(shift_busy));
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checks++;
    if (sn !== ex)
    begin
      $display("[ERR] %s expected %h seen %h", nm, ex, sn);
      err_total++;
    end
  endtask : cmp
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge so a following request never reassigns psel in this step
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] ex);
    apb(0, a, 0);
    cmp("prdata", ex, r);
  endtask : chk
  task automatic recv(input logic [15:0] wv, input logic [4:0] ev);
    go <= 1; wb <= wv; eb <= ev;
    @(posedge pclk) go <= 0;
    repeat (2) @(posedge pclk);
  endtask : recv
  task automatic errpulse;
    err_ev <= 1;
    @(posedge pclk) err_ev <= 0;
    repeat (2) @(posedge pclk);
  endtask : errpulse
  task automatic t_basic;
    chk(srbs_pkg::OFF_RX_BUF, 32'h80000000);
    recv(16'hA5C3, 5'h1F);
    chk(srbs_pkg::OFF_FLAGS, 32'h1);
    chk(srbs_pkg::OFF_RX_BUF, 32'h1F00A5C3);
    chk(srbs_pkg::OFF_FLAGS, 32'h0);
    chk(srbs_pkg::OFF_RX_BUF, 32'h8700A5C3);
    apb(1, srbs_pkg::OFF_RX_BUF, 32'hFFFFFFFF);
    chk(srbs_pkg::OFF_RX_BUF, 32'h8700A5C3);
  endtask : t_basic
  task automatic t_ovr;
    recv(16'h1, 0); recv(16'h2, 0); recv(16'h3, 0);
    chk(srbs_pkg::OFF_RX_BUF, 32'h40000001);
    chk(srbs_pkg::OFF_RX_BUF, 32'h40000003);
    chk(srbs_pkg::OFF_RX_BUF, 32'hC0000003);
    apb(1, srbs_pkg::OFF_FLAGS, 32'h2);
    chk(srbs_pkg::OFF_RX_BUF, 32'h80000003);
    recv(16'h0BEE, 0);
    apb(1, srbs_pkg::OFF_FLAGS, 32'h1);
    chk(srbs_pkg::OFF_RX_BUF, 32'h80000BEE);
    recv(16'h0011, 0); recv(16'h0022, 0);
    errpulse();
    chk(srbs_pkg::OFF_RX_BUF, 32'h40000011);
    chk(srbs_pkg::OFF_RX_BUF, 32'h40000022);
    apb(1, srbs_pkg::OFF_FLAGS, 32'h2);
    chk(srbs_pkg::OFF_RX_BUF, 32'h80000022);
  endtask : t_ovr
  task automatic t_tx;
    apb(1, srbs_pkg::OFF_TX_DATA, 32'h1234);
    apb(1, srbs_pkg::OFF_TX_DATA, 32'h5678);
    chk(srbs_pkg::OFF_FLAGS, 32'h4);
    repeat (16) @(posedge pclk);
    chk(srbs_pkg::OFF_FLAGS, 32'h0);
    cmp("tx_start count", 32'd2, 32'(nstart));
  endtask : t_tx
  task automatic t_irq;
    apb(1, srbs_pkg::OFF_IRQ_CLEAR, 32'hF);
    apb(1, srbs_pkg::OFF_IRQ_ENABLE, 32'h1);
    recv(16'h0042, 0);
    cmp("irq", 32'h1, {31'h0, irq});
    chk(srbs_pkg::OFF_IRQ_STATUS, 32'h1);
    apb(1, srbs_pkg::OFF_IRQ_ENABLE, 32'h0);
    cmp("irq", 32'h0, {31'h0, irq});
    apb(1, srbs_pkg::OFF_IRQ_ENABLE, 32'h1);
    cmp("irq", 32'h1, {31'h0, irq});
    apb(1, srbs_pkg::OFF_IRQ_CLEAR, 32'h1);
    cmp("irq", 32'h0, {31'h0, irq});
    apb(0, 8'h40, 32'h0);
    cmp("pslverr", 32'h1, {31'h0, e});
    cmp("prdata", 32'h0, r);
  endtask : t_irq
  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    #100000;
    err_total++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_basic();
    t_ovr();
    t_tx();
    t_irq();
    conclude();
  end
endmodule : test_spi_receive_buffer_status
bind srbs_receive_buffer srbs_checker srbs_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .shift_busy(shift_busy),
  .tx_start(tx_start), .tx_word(tx_word), .irq(irq));

// ### verilog/srbs_pkg.sv
// Constants, register map and carrier types for the receive buffer block
package srbs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RX_BUF     = 8'h00;
  localparam logic [7:0] OFF_FLAGS      = 8'h04;
  localparam logic [7:0] OFF_TX_DATA    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;

  // Receive buffer register fields
  localparam int BIT_RX_EMPTY = 31;
  localparam int BIT_RX_OVR   = 30;
  localparam int BIT_TX_FULL  = 29;
  localparam int ERR_LSB      = 24;
  localparam int WORD_W       = 16;
  localparam int ERR_W        = 5;

  // Flag register fields
  localparam int FLG_RX_INT = 0;
  localparam int FLG_RX_OVR = 1;
  localparam int FLG_TX_FUL = 2;

  // Interrupt event bits
  localparam int EV_RX_DATA = 0;
  localparam int EV_RX_ERR  = 1;
  localparam int EV_RX_OVR  = 2;
  localparam int EV_TX_ROOM = 3;
  localparam int EV_W       = 4;

  // Values after reset
  localparam logic            RST_RX_EMPTY = 1'b1;
  localparam logic [EV_W-1:0] RST_IRQ_EN   = 4'h0;

  // Per-word error status, ordered as bits 28 down to 24
  typedef struct packed {
    logic bit_mismatch_flag;
    logic desync_flag;
    logic parity_fault_flag;
    logic timeout_flag;
    logic length_fault_flag;
  } srbs_err_t;

  // One received word with its status
  typedef struct packed {
    srbs_err_t         err;
    logic [WORD_W-1:0] word;
  } srbs_entry_t;

  // Whole block state
  typedef struct packed {
    srbs_entry_t       vis;
    logic              rx_empty_flag;
    srbs_entry_t       hold;
    logic              hold_full;
    logic              rx_overrun_flag;
    logic              rx_interrupt_flag;
    logic              tx_full_flag;
    logic [WORD_W-1:0] tx_holding_buffer;
    logic              tx_start;
    logic [WORD_W-1:0] tx_word;
    logic [EV_W-1:0]   irq_status;
    logic [EV_W-1:0]   irq_enable;
    logic              ack;
    logic [31:0]       rdata;
    logic              slverr;
  } srbs_state_t;

endpackage : srbs_pkg

// ### verilog/srbs_receive_buffer.sv
// Two-stage receive buffer with status flags, transmit-full tracking and APB access
//
// Contract
// RULE1 - Host read of the buffer register sets the receive-empty flag (bit 31).
// RULE2 - Completed transfer fills the visible register and clears receive-empty.
// RULE3 - Write-one clear of receive-interrupt flag also sets receive-empty.
// RULE4 - Reading the buffer register clears the receive-interrupt flag.
// RULE5 - Overrun flag (bit 30) sets when a word lands in a full holding buffer.
// RULE6 - Overruns land in the holding buffer; the visible word stays until read.
// RULE7 - Reading the buffer register leaves the overrun flag unchanged.
// RULE8 - Each buffer read moves a full holding buffer into the visible register.
// RULE9 - Error during receive with both stages full also sets the overrun flag.
// RULE10 - Bit-mismatch and desync flags clear when the buffer register is read.
// RULE11 - Transmit-full sets on a write while shift register busy, clears on load.
// RULE12 - Reserved bits read zero; writes to the buffer register change nothing.
// RULE13 - Error flags travel with their word through both buffer stages.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module srbs_receive_buffer (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // From the shift engine, receive side
  input  wire logic                            rx_done,
  input  wire logic [srbs_pkg::WORD_W-1:0]     rx_word,
  input  wire srbs_pkg::srbs_err_t             rx_err,
  input  wire logic                            rx_busy,
  input  wire logic                            rx_err_event,
  // To and from the shift engine, transmit side
  input  wire logic                            shift_busy,
  output logic                                 tx_start,
  output logic      [srbs_pkg::WORD_W-1:0]     tx_word,
  // Interrupt
  output logic                                 irq
);

  srbs_pkg::srbs_state_t s_q;
  srbs_pkg::srbs_state_t s_d;

  logic                      access;
  logic                      wr;
  logic                      rd;
  logic                      sel_buf;
  logic                      sel_flg;
  logic                      sel_tx;
  logic                      sel_sts;
  logic                      sel_clr;
  logic                      sel_en;
  logic                      mapped;
  logic [31:0]               buf_view;
  logic [31:0]               flg_view;
  logic [srbs_pkg::EV_W-1:0] ev;
  logic [srbs_pkg::EV_W-1:0] irq_pend;

  // Effects land on the first access cycle; pready follows one cycle later
  assign access  = psel & penable & ~s_q.ack;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  assign sel_buf = paddr == srbs_pkg::OFF_RX_BUF;
  assign sel_flg = paddr == srbs_pkg::OFF_FLAGS;
  assign sel_tx  = paddr == srbs_pkg::OFF_TX_DATA;
  assign sel_sts = paddr == srbs_pkg::OFF_IRQ_STATUS;
  assign sel_clr = paddr == srbs_pkg::OFF_IRQ_CLEAR;
  assign sel_en  = paddr == srbs_pkg::OFF_IRQ_ENABLE;
  assign mapped  = sel_buf | sel_flg | sel_tx | sel_sts | sel_clr | sel_en;

  always_comb
  begin
    buf_view = 32'h0000_0000; // RULE12
    buf_view[srbs_pkg::BIT_RX_EMPTY] = s_q.rx_empty_flag;
    buf_view[srbs_pkg::BIT_RX_OVR]   = s_q.rx_overrun_flag;
    buf_view[srbs_pkg::BIT_TX_FULL]  = s_q.tx_full_flag;
    buf_view[srbs_pkg::ERR_LSB +: srbs_pkg::ERR_W] = s_q.vis.err;
    buf_view[srbs_pkg::WORD_W-1:0] = s_q.vis.word;
    flg_view = 32'h0000_0000;
    flg_view[srbs_pkg::FLG_RX_INT] = s_q.rx_interrupt_flag;
    flg_view[srbs_pkg::FLG_RX_OVR] = s_q.rx_overrun_flag;
    flg_view[srbs_pkg::FLG_TX_FUL] = s_q.tx_full_flag;
  end

  always_comb
  begin
    s_d          = s_q;
    ev           = '0;
    s_d.tx_start = 1'b0;
    s_d.ack      = access;

    // Host read of the buffer register
    if (rd && sel_buf)
    begin
      s_d.rx_empty_flag         = 1'b1; // RULE1
      s_d.rx_interrupt_flag     = 1'b0; // RULE4
      s_d.vis.err.bit_mismatch_flag = 1'b0; // RULE10
      s_d.vis.err.desync_flag   = 1'b0; // RULE10
      if (s_q.hold_full)
      begin
        s_d.vis               = s_q.hold; // RULE8 RULE13
        s_d.hold_full         = 1'b0;
        s_d.rx_empty_flag     = 1'b0;
        s_d.rx_interrupt_flag = 1'b1;
        ev[srbs_pkg::EV_RX_DATA] = 1'b1;
      end
    end

    // Flag register: write one to clear
    if (wr && sel_flg)
    begin
      if (pwdata[srbs_pkg::FLG_RX_INT])
      begin
        s_d.rx_interrupt_flag = 1'b0;
        s_d.rx_empty_flag     = 1'b1; // RULE3
      end
      if (pwdata[srbs_pkg::FLG_RX_OVR])
        s_d.rx_overrun_flag = 1'b0;
    end

    // Interrupt enable and clear
    if (wr && sel_en)
      s_d.irq_enable = pwdata[srbs_pkg::EV_W-1:0];
    if (wr && sel_clr)
      s_d.irq_status = s_d.irq_status & ~pwdata[srbs_pkg::EV_W-1:0];

    // Completed transfer; handled after the clears so a same-cycle event wins
    if (rx_done)
    begin
      if (s_d.rx_empty_flag && !s_d.hold_full)
      begin
        s_d.vis.word          = rx_word; // RULE2
        s_d.vis.err           = rx_err; // RULE13
        s_d.rx_empty_flag     = 1'b0; // RULE2
        s_d.rx_interrupt_flag = 1'b1;
      end
      else
      begin
        // Visible word is never overwritten while the receive-empty flag is clear
        if (s_d.hold_full)
        begin
          s_d.rx_overrun_flag = 1'b1; // RULE5
          ev[srbs_pkg::EV_RX_OVR] = 1'b1;
        end
        s_d.hold.word = rx_word; // RULE6
        s_d.hold.err  = rx_err; // RULE13
        s_d.hold_full = 1'b1;
      end
      ev[srbs_pkg::EV_RX_DATA] = 1'b1;
      ev[srbs_pkg::EV_RX_ERR]  = |rx_err;
    end

    // Status of a further word is about to be lost
    if (rx_err_event && rx_busy && !s_d.rx_empty_flag && s_d.hold_full)
    begin
      s_d.rx_overrun_flag = 1'b1; // RULE9
      ev[srbs_pkg::EV_RX_OVR] = 1'b1;
    end

    // Transmit side; a buffered word waits for the shift register to free up
    if (s_q.tx_full_flag && !shift_busy)
    begin
      s_d.tx_start     = 1'b1;
      s_d.tx_word      = s_q.tx_holding_buffer;
      s_d.tx_full_flag = 1'b0; // RULE11
      ev[srbs_pkg::EV_TX_ROOM] = 1'b1;
    end
    if (wr && sel_tx)
    begin
      if (shift_busy || s_q.tx_full_flag)
      begin
        // A write over a full buffer replaces the waiting word
        s_d.tx_holding_buffer = pwdata[srbs_pkg::WORD_W-1:0];
        s_d.tx_full_flag      = 1'b1; // RULE11
      end
      else
      begin
        s_d.tx_start = 1'b1;
        s_d.tx_word  = pwdata[srbs_pkg::WORD_W-1:0];
      end
    end

    // Sticky interrupt status; set wins over clear
    s_d.irq_status = s_d.irq_status | ev;

    // Read data captured on the access edge, before this cycle's effects
    s_d.rdata  = 32'h0000_0000;
    s_d.slverr = access & ~mapped;
    if (rd)
    begin
      if (sel_buf)
        s_d.rdata = buf_view;
      else if (sel_flg)
        s_d.rdata = flg_view;
      else if (sel_sts)
        s_d.rdata[srbs_pkg::EV_W-1:0] = s_q.irq_status;
      else if (sel_en)
        s_d.rdata[srbs_pkg::EV_W-1:0] = s_q.irq_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q               <= '0;
      s_q.rx_empty_flag <= srbs_pkg::RST_RX_EMPTY;
      s_q.irq_enable    <= srbs_pkg::RST_IRQ_EN;
    end
    else
      s_q <= s_d;
  end

  assign prdata   = s_q.rdata;
  assign pready   = s_q.ack;
  assign pslverr  = s_q.ack & s_q.slverr;
  assign tx_start = s_q.tx_start;
  assign tx_word  = s_q.tx_word;
  // Per-event gate so each source can be masked alone
  for (genvar g = 0; g < srbs_pkg::EV_W; g++)
  begin : g_irq
    assign irq_pend[g] = s_q.irq_status[g] & s_q.irq_enable[g];
  end

  // Level interrupt, high while any enabled sticky bit is set
  assign irq      = |irq_pend;

endmodule : srbs_receive_buffer
